//--- verilog/tbpw_top.v
// Two-channel ten-bit modulator with shared period timer, AHB-Lite slave
// Behaviour
// - Time base runs from system clock
// - Reset returns pins to input, registers cleared; the code resets period to FF and keeps the duty bytes
// - Control bit 7 enables modulator
// - Control bit 6 routes output to pin
// - Control bit 5 reads current output
// - Bit 4 inverts polarity; bits 3-0 zero
// - Duty high holds eight upper bits
// - Duty low bits 7:6; rest read zero
// - Set at timer clear, clear at match
// - Duty double buffered, loaded at period match
// - Ten-bit base from timer plus two bits
// - Zero duty keeps output inactive
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tbpw_defs.vh"
module tbpw_top (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Modulator pins and internal outputs
	output reg  [1:0]  pwm_pin_out,
	output reg  [1:0]  pwm_pin_oe_n,
	output reg  [1:0]  pwm_internal
);

	// ----------------------------------------
	// Bus capture
	// ----------------------------------------
	reg        wr_pend_reg;
	reg  [5:0] wr_addr_reg;
	wire       acc = hsel & hready & (htrans == `TBPW_HTRANS_NONSEQ);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [3:0] ctrl_reg [0:1];
	reg  [7:0] dch_reg  [0:1];
	reg  [1:0] dcl_reg  [0:1];
	reg  [9:0] dbuf_reg [0:1];
	reg  [7:0] period_reg;
	reg  [7:0] timer_reg;
	reg  [5:0] pre_reg;
	reg  [1:0] ps_sel_reg;
	reg        trun_reg;
	reg        flag_reg;
	reg  [1:0] dir_reg;
	reg  [1:0] latch_reg;
	reg  [1:0] mod_reg;

	// Ten-bit base low bits: clock phase at 1:1, prescaler top bits otherwise
	// base extension bits
	function [1:0] base_low;
		input [1:0] sel;
		input [5:0] pre;
		begin
			case (sel)
				`TBPW_PS_1:  base_low = pre[1:0];
				`TBPW_PS_4:  base_low = pre[3:2];
				default:     base_low = pre[5:4];
			endcase
		end
	endfunction

	// Prescaler terminal count: four base ticks per timer step at every ratio
	function pre_last;
		input [1:0] sel;
		input [5:0] pre;
		begin
			case (sel)
				`TBPW_PS_1:  pre_last = (pre[1:0] == `TBPW_PS1_LAST);
				`TBPW_PS_4:  pre_last = (pre[3:0] == `TBPW_PS_MAX);
				default:     pre_last = (pre == `TBPW_PS16_LAST);
			endcase
		end
	endfunction

	// Write strike: a pending data phase aimed at one offset
	function wr_hit;
		input       pend;
		input [5:0] addr;
		input [5:0] ofs;
		begin
			wr_hit = pend & (addr == ofs);
		end
	endfunction

	wire        step  = trun_reg & pre_last(ps_sel_reg, pre_reg);
	wire        pmatch = step & (timer_reg == period_reg);
	wire [9:0]  tbase = {timer_reg, base_low(ps_sel_reg, pre_reg)};
	wire        wr_now = wr_pend_reg;
	wire [7:0]  wdat  = hwdata[7:0];

	// ----------------------------------------
	// Write strobes
	// ----------------------------------------
	wire        wr_period = wr_hit(wr_now, wr_addr_reg, `TBPW_OFS_PERIOD);
	wire        wr_timer  = wr_hit(wr_now, wr_addr_reg, `TBPW_OFS_TIMER);
	wire        wr_tctrl  = wr_hit(wr_now, wr_addr_reg, `TBPW_OFS_TCTRL);
	wire        wr_flag   = wr_hit(wr_now, wr_addr_reg, `TBPW_OFS_FLAG);
	wire        wr_dir    = wr_hit(wr_now, wr_addr_reg, `TBPW_OFS_DIR);
	wire        wr_latch  = wr_hit(wr_now, wr_addr_reg, `TBPW_OFS_LATCH);

	// ----------------------------------------
	// Shared timer
	// ----------------------------------------
	// prescaler supplies the base low bits
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_reg <= `TBPW_PRE_RST;
		end else if (trun_reg) begin
			pre_reg <= pre_last(ps_sel_reg, pre_reg) ? `TBPW_PRE_RST : pre_reg + 6'h01;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_reg <= `TBPW_ZERO8;
		end else if (wr_timer) begin
			timer_reg <= wdat;
		end else if (pmatch) begin
			timer_reg <= `TBPW_ZERO8;
		end else if (step) begin
			timer_reg <= timer_reg + 8'h01;
		end
	end

	// Period compare is live: a period below the running count lets the timer wrap first
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_reg <= `TBPW_PERIOD_RST;
			ps_sel_reg <= `TBPW_PS_1;
			trun_reg   <= 1'b0;
		end else begin
			if (wr_period) begin
				period_reg <= wdat;
			end
			if (wr_tctrl) begin
				ps_sel_reg <= wdat[1:0];
				trun_reg   <= wdat[`TBPW_TRUN_BIT];
			end
		end
	end

	// Overflow flag: set wins over a software clear in the same cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_reg <= 1'b0;
		end else if (pmatch) begin
			flag_reg <= 1'b1;
		end else if (wr_flag) begin
			flag_reg <= wdat[`TBPW_FLAG_BIT];
		end
	end

	// ----------------------------------------
	// Port direction and latch
	// ----------------------------------------
	// pins return to input on reset
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_reg   <= `TBPW_DIR_RST;
			latch_reg <= 2'h0;
		end else begin
			if (wr_dir) begin
				dir_reg <= wdat[1:0];
			end
			if (wr_latch) begin
				latch_reg <= wdat[1:0];
			end
		end
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : ch
			wire [5:0] oc = g ? `TBPW_OFS_CTRL1  : `TBPW_OFS_CTRL0;
			wire [5:0] oh = g ? `TBPW_OFS_DUTYH1 : `TBPW_OFS_DUTYH0;
			wire [5:0] ol = g ? `TBPW_OFS_DUTYL1 : `TBPW_OFS_DUTYL0;
			wire       wr_ctrl = wr_hit(wr_now, wr_addr_reg, oc);
			wire       wr_dch  = wr_hit(wr_now, wr_addr_reg, oh);
			wire       wr_dcl  = wr_hit(wr_now, wr_addr_reg, ol);
			// output already low in the cycle the base reaches the duty
			wire       at_duty = (tbase == dbuf_reg[g]);
			// Duty bytes have no reset, so a warm reset leaves the duty as written
			// duty high and low read/write
			always @(posedge hclk) begin
				if (wr_dch) begin
					dch_reg[g] <= wdat;
				end
				if (wr_dcl) begin
					dcl_reg[g] <= wdat[7:6];
				end
			end
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					ctrl_reg[g] <= `TBPW_CTRL_RST;
					dbuf_reg[g] <= `TBPW_ZERO10;
					mod_reg[g]  <= 1'b0;
				end else begin
					// enable, pin route, polarity; bit 5 ignored
					if (wr_ctrl) begin
						ctrl_reg[g] <= {wdat[`TBPW_EN_BIT], wdat[`TBPW_OE_BIT], 1'b0,
							wdat[`TBPW_POL_BIT]};
					end
					if (pmatch) begin
						dbuf_reg[g] <= {dch_reg[g], dcl_reg[g]};
					end
					if (!ctrl_reg[g][3]) begin
						mod_reg[g] <= 1'b0;
					// set at restart; zero duty stays low
					end else if (pmatch) begin
						mod_reg[g] <= ({dch_reg[g], dcl_reg[g]} != `TBPW_ZERO10);
					// clear on match; never when duty beyond period
					end else if (at_duty) begin
						mod_reg[g] <= 1'b0;
					end
				end
			end
			wire act = (mod_reg[g] & ~at_duty) ^ ctrl_reg[g][0];
			// pin carries output only with pin route (control bit 6) and output direction
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pwm_internal[g] <= 1'b0;
					pwm_pin_out[g]  <= 1'b0;
					pwm_pin_oe_n[g] <= 1'b1;
				end else begin
					pwm_internal[g] <= act;
					pwm_pin_out[g]  <= ctrl_reg[g][2] ? act : latch_reg[g];
					pwm_pin_oe_n[g] <= dir_reg[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	// register readback, output value at control bit 5
	reg [7:0] rd_byte;
	always @* begin
		rd_byte = `TBPW_ZERO8;
		case (haddr[5:0])
			`TBPW_OFS_CTRL0:  rd_byte = {ctrl_reg[0][3:2], pwm_internal[0], ctrl_reg[0][0], 4'h0};
			`TBPW_OFS_CTRL1:  rd_byte = {ctrl_reg[1][3:2], pwm_internal[1], ctrl_reg[1][0], 4'h0};
			`TBPW_OFS_DUTYH0: rd_byte = dch_reg[0];
			`TBPW_OFS_DUTYH1: rd_byte = dch_reg[1];
			`TBPW_OFS_DUTYL0: rd_byte = {dcl_reg[0], 6'h00};
			`TBPW_OFS_DUTYL1: rd_byte = {dcl_reg[1], 6'h00};
			`TBPW_OFS_PERIOD: rd_byte = period_reg;
			`TBPW_OFS_TCTRL:  rd_byte = {5'h00, trun_reg, ps_sel_reg};
			`TBPW_OFS_TIMER:  rd_byte = timer_reg;
			`TBPW_OFS_FLAG:   rd_byte = {7'h00, flag_reg};
			`TBPW_OFS_DIR:    rd_byte = {6'h00, dir_reg};
			`TBPW_OFS_LATCH:  rd_byte = {6'h00, latch_reg};
			default:          rd_byte = `TBPW_ZERO8;
		endcase
	end

	// Zero-wait slave; unmapped addresses read zero and ignore writes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 6'h00;
			hrdata      <= 32'h00000000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else begin
			wr_pend_reg <= acc & hwrite;
			wr_addr_reg <= haddr[5:0];
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			if (acc && !hwrite) begin
				hrdata <= {24'h000000, rd_byte};
			end
		end
	end

endmodule

//--- verilog/tbpw_defs.vh
// Constants for the ten-bit modulator block
`ifndef TBPW_DEFS_VH
`define TBPW_DEFS_VH
// Register byte offsets
`define TBPW_OFS_CTRL0     6'h00
`define TBPW_OFS_DUTYH0    6'h04
`define TBPW_OFS_DUTYL0    6'h08
`define TBPW_OFS_CTRL1     6'h0C
`define TBPW_OFS_DUTYH1    6'h10
`define TBPW_OFS_DUTYL1    6'h14
`define TBPW_OFS_PERIOD    6'h18
`define TBPW_OFS_TCTRL     6'h1C
`define TBPW_OFS_TIMER     6'h20
`define TBPW_OFS_FLAG      6'h24
`define TBPW_OFS_DIR       6'h28
`define TBPW_OFS_LATCH     6'h2C
// Control fields
`define TBPW_EN_BIT        7
`define TBPW_OE_BIT        6
`define TBPW_OUT_BIT       5
`define TBPW_POL_BIT       4
`define TBPW_TRUN_BIT      2
// Reset values
`define TBPW_CTRL_RST      4'h0
`define TBPW_PERIOD_RST    8'hFF
`define TBPW_DIR_RST       2'h3
`define TBPW_ZERO8         8'h00
`define TBPW_ZERO10        10'h000
// Prescale selections
`define TBPW_PS_1          2'h0
`define TBPW_PS_4          2'h1
`define TBPW_PS_16         2'h2
`define TBPW_PS_MAX        4'hF
`define TBPW_PRE_RST       6'h00
`define TBPW_PS1_LAST      2'h3
`define TBPW_PS16_LAST     6'h3F
`define TBPW_FLAG_BIT      0
`define TBPW_HTRANS_NONSEQ 2'h2
`endif

//--- dv/tbpw_properties.sv
// Bus and pin checks for the modulator block
`timescale 1ns/1ps
module tbpw_properties (
	// Clock and reset
	input wire        hclk,
	input wire        hresetn,
	// Bus
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	// Pins
	input wire [1:0]  pwm_pin_oe_n,
	input wire [1:0]  pwm_internal
);
	reg [5:0] a_reg;
	reg       rd_reg;
	reg       wr_reg;
	reg [1:0] dir_reg;
	// Shadow of the direction register, to judge the pin enables
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_reg   <= 6'h00;
			rd_reg  <= 1'h0;
			wr_reg  <= 1'h0;
			dir_reg <= 2'h3;
		end else begin
			if (wr_reg && a_reg == 6'h28)
				dir_reg <= hwdata[1:0];
			rd_reg <= hsel && hready && htrans == 2'h2 && !hwrite;
			wr_reg <= hsel && hready && htrans == 2'h2 && hwrite;
			a_reg  <= haddr[5:0];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_reset_pins: assert property ($rose(hresetn) |-> pwm_pin_oe_n == 2'h3 && !pwm_internal)
		else $error("pins not idle after reset");
	a_ctrl_spare: assert property (rd_reg && a_reg == 6'h00 |-> hrdata[31:0] < 32'h100 && !hrdata[3:0])
		else $error("control spare bits set");
	a_dutyl_spare: assert property (rd_reg && a_reg == 6'h08 |-> hrdata[5:0] == 6'h00)
		else $error("duty low spare bits set");
	a_unmapped_zero: assert property (rd_reg && a_reg >= 6'h30 |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_dir_follow: assert property (dir_reg == $past(dir_reg) |-> ##1 pwm_pin_oe_n == $past(dir_reg))
		else $error("pin enable not direction");
	a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
endmodule
bind tbpw_top tbpw_properties u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_pin_oe_n(pwm_pin_oe_n),
	.pwm_internal(pwm_internal));

//--- dv/tbpw_pin_load.sv
// Port pin load on the modulator outputs
`timescale 1ns/1ps
module tbpw_pin_load (
	// From the block
	input wire [1:0]  pin_out,
	input wire [1:0]  pin_oe_n,
	// Pad level
	output wire [1:0] pin_level
);
	// pad driven only while enable low; pull-up holds a released pad high
	assign pin_level = (pin_out & ~pin_oe_n) | pin_oe_n;
endmodule

//--- dv/tbpw_tb.sv
// Self-checking bench for the modulator block
`timescale 1ns/1ps
module tb;
	logic        hclk = 0;
	logic        hresetn = 0;
	logic        hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0]  htrans = 0;
	logic        hwrite = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire  [1:0]  pout;
	wire  [1:0]  oe_n;
	wire  [1:0]  pint;
	wire  [1:0]  pad;
	int          n_mismatch = 0;
	int          total_checks = 0;
	always #5 hclk = ~hclk;
	tbpw_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_pin_out(pout),
		.pwm_pin_oe_n(oe_n), .pwm_internal(pint));
	tbpw_pin_load load (.pin_out(pout), .pin_oe_n(oe_n), .pin_level(pad));
	task complete_run;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Bounded wait for the ready edge
	task wait_ready;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'h1 && i < 50);
		if (hreadyout !== 1'h1) begin
			n_mismatch++;
			complete_run;
		end
	endtask
	task xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
		hsel <= 1'h1;
		haddr <= {26'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_ready;
		rd = hrdata;
	endtask
	task t_regs;
		chk("oe_n", {30'h0, oe_n}, 32'h3);
		xfer(0, 6'h18, 8'h00);
		chk("period", rd, 32'hFF);
		xfer(1, 6'h00, 8'h3F);
		repeat (4) @(posedge hclk);
		xfer(0, 6'h00, 8'h00);
		chk("ctrl0", rd, 32'h30);
		xfer(1, 6'h08, 8'hFF);
		xfer(0, 6'h08, 8'h00);
		chk("dutyl", rd, 32'hC0);
		xfer(1, 6'h04, 8'hA5);
		xfer(0, 6'h04, 8'h00);
		chk("dutyh", rd, 32'hA5);
		xfer(1, 6'h30, 8'h5A);
		xfer(0, 6'h30, 8'h00);
		chk("unmapped", rd, 32'h0);
	endtask
	task t_setup;
		int i;
		// steps kept in order, so the first period is complete
		// driver off, control clear, short period, duty clear
		xfer(1, 6'h28, 8'h03);
		xfer(1, 6'h00, 8'h00);
		xfer(1, 6'h18, 8'h03);
		xfer(1, 6'h04, 8'h00);
		xfer(1, 6'h08, 8'h00);
		// clear flag, run timer at 1:1, wait for overflow
		xfer(1, 6'h24, 8'h00);
		xfer(1, 6'h1C, 8'h04);
		i = 0;
		do begin
			xfer(0, 6'h24, 8'h00);
			i++;
		end while (rd !== 32'h1 && i < 20);
		chk("flag", rd, 32'h1);
		// channel 1 stays internal, channel 0 gets the pin
		xfer(1, 6'h28, 8'h02);
		xfer(1, 6'h10, 8'h00);
		xfer(1, 6'h14, 8'h80);
		xfer(1, 6'h0C, 8'h80);
	endtask
	// Counts only whole periods, so the start phase does not matter
	task t_duty;
		logic [31:0] tab [5] = '{32'hC0018018, 32'hC0000000, 32'hC0FFC040,
			32'hD0018028, 32'h10018040};
		logic [7:0] c0, cp, c1;
		foreach (tab[k]) begin
			xfer(1, 6'h04, tab[k][23:16]);
			xfer(1, 6'h08, tab[k][15:8]);
			xfer(1, 6'h00, tab[k][31:24]);
			repeat (32) @(posedge hclk);
			c0 = 0;
			cp = 0;
			c1 = 0;
			repeat (64) begin
				@(posedge hclk);
				c0 = c0 + pint[0];
				cp = cp + pad[0];
				c1 = c1 + pint[1];
			end
			chk("duty", {24'h0, c0}, {24'h0, tab[k][7:0]});
			chk("pin", {24'h0, cp}, tab[k][30] ? {24'h0, tab[k][7:0]} : 32'h0);
			chk("chan1", {24'h0, c1}, 32'h8);
		end
		chk("oe_n", {30'h0, oe_n}, 32'h2);
	endtask
	// Duties 6 and 2 at 1:4 then 1:16; each window is one whole period
	task t_scale;
		int c0, c1, n;
		xfer(1, 6'h00, 8'h80);
		for (int s = 1; s < 3; s++) begin
			n = 1 << (2 * s);
			xfer(1, 6'h1C, {6'h01, s[1:0]});
			repeat (32 * n) @(posedge hclk);
			c0 = 0;
			c1 = 0;
			repeat (16 * n) begin
				@(posedge hclk);
				c0 += pint[0];
				c1 += pint[1];
			end
			chk("scale ch0", c0, 6 * n);
			chk("scale ch1", c1, 2 * n);
		end
	endtask
	// Mid-run reset: pins to input, control and period reset, duty kept
	task t_reset;
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		chk("rst oe_n", {30'h0, oe_n}, 32'h3);
		xfer(0, 6'h00, 8'h00);
		chk("rst ctrl0", rd, 32'h0);
		xfer(0, 6'h18, 8'h00);
		chk("rst period", rd, 32'hFF);
		xfer(0, 6'h04, 8'h00);
		chk("kept dutyh", rd, 32'h1);
		xfer(0, 6'h08, 8'h00);
		chk("kept dutyl", rd, 32'h80);
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		t_regs;
		t_setup;
		t_duty;
		t_scale;
		t_reset;
		complete_run;
	end
endmodule
